/* hsd_chk.sv */
// hsd_chk: bus handshake and clock relation assertions for hsd_top
`timescale 1ns/10ps
`default_nettype none
module hsd_chk (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic sysclk_source_is_low_speed,
  input wire logic low_speed_oscillator,
  input wire logic clock_output_port_enable,
  input wire logic system_clock,
  input wire logic external_bus_clock_pin,
  input wire logic rom_controller_clock,
  input wire logic core_peripheral_clock
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  property p_wait_ans;
    $rose(avs_read || avs_write) |=> !avs_waitrequest;
  endproperty
  a_wait_ans: assert property (p_wait_ans) else $error("no answer one cycle after request");
  property p_wait_one;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long");
  property p_pin_off;
    !$past(clock_output_port_enable) |-> !external_bus_clock_pin;
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("clock pin active while unassigned");
  property p_pin_rise;
    $rose(external_bus_clock_pin) |-> $past(clock_output_port_enable);
  endproperty
  a_pin_rise: assert property (p_pin_rise) else $error("clock pin rose without port");
  property p_ls_sys;
    sysclk_source_is_low_speed [*4] |-> system_clock == $past(low_speed_oscillator);
  endproperty
  a_ls_sys: assert property (p_ls_sys) else $error("system clock not low speed source");
  property p_pclk_rise;
    $rose(core_peripheral_clock) |-> $past(system_clock);
  endproperty
  a_pclk_rise: assert property (p_pclk_rise) else $error("peripheral clock rose alone");
  property p_pclk_fall;
    $fell(core_peripheral_clock) |-> !$past(system_clock);
  endproperty
  a_pclk_fall: assert property (p_pclk_fall) else $error("peripheral clock pulse cut");
  property p_rom_rise;
    $rose(rom_controller_clock) |-> $past(system_clock);
  endproperty
  a_rom_rise: assert property (p_rom_rise) else $error("rom clock rose alone");
  property p_rom_fall;
    $fell(rom_controller_clock) |-> !$past(system_clock);
  endproperty
  a_rom_fall: assert property (p_rom_fall) else $error("rom clock pulse cut");
endmodule // hsd_chk
bind hsd_top hsd_chk u_chk (.ref_clk(ref_clk), .sys_rst(sys_rst), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .sysclk_source_is_low_speed(sysclk_source_is_low_speed),
  .low_speed_oscillator(low_speed_oscillator),
  .clock_output_port_enable(clock_output_port_enable), .system_clock(system_clock),
  .external_bus_clock_pin(external_bus_clock_pin), .rom_controller_clock(rom_controller_clock),
  .core_peripheral_clock(core_peripheral_clock));
`default_nettype wire

/* hsd_clk_gate.sv */
// hsd_clk_gate: clock gate whose enable is only taken while the source clock is low
`timescale 1ns/10ps
`default_nettype none
module hsd_clk_gate (
  input wire logic clk,
  input wire logic rst,
  input wire logic clk_src,
  input wire logic enable,
  output logic gated_q
);
  logic en_q, en_d;
  logic out_d;

  // enable only moves while the source is low, so no pulse is ever cut short
  always_comb begin
    en_d = en_q;
    if (!clk_src) begin
      en_d = enable;
    end
    out_d = clk_src & en_q;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      en_q <= 1'b1;
      gated_q <= 1'b0;
    end else begin
      en_q <= en_d;
      gated_q <= out_d;
    end
  end
endmodule // hsd_clk_gate
`default_nettype wire

/* hsd_pkg.sv */
// hsd_pkg: register map, field layout, reset values and codes for the clock divider block
package hsd_pkg;
  localparam int unsigned HSD_ADDR_W = 17;
  localparam int unsigned HSD_DATA_W = 32;
  // printed offsets are register indices; byte address is four times the index
  localparam logic [14:0] HSD_IDX_NF = 15'h4902;
  localparam logic [14:0] HSD_IDX_DIV = 15'h4903;
  localparam logic [14:0] HSD_IDX_BUSSEL = 15'h4905;
  localparam logic [14:0] HSD_IDX_GATE0 = 15'h4906;
  localparam logic [14:0] HSD_IDX_PROT = 15'h4920;
  localparam logic [14:0] HSD_IDX_STATUS = 15'h4921;
  localparam logic [14:0] HSD_IDX_PROT_LO = 15'h4900;
  localparam logic [14:0] HSD_IDX_PROT_HI = 15'h4908;
  // field positions
  localparam int unsigned HSD_NF_BYPASS_BIT = 0;
  localparam int unsigned HSD_DIV_W = 3;
  localparam int unsigned HSD_BUSSEL_W = 4;
  localparam int unsigned HSD_GATE_ROM_BIT = 7;
  localparam int unsigned HSD_GATE_PCLK_BIT = 0;
  localparam int unsigned HSD_ST_SRC_BIT = 3;
  // reset values
  localparam logic HSD_NF_BYPASS_RST = 1'b1;
  localparam logic [2:0] HSD_DIV_RST = 3'h0;
  localparam logic [3:0] HSD_BUSSEL_RST = 4'h0;
  localparam logic HSD_GATE_ROM_RST = 1'b1;
  localparam logic HSD_GATE_PCLK_RST = 1'b1;
  localparam logic [7:0] HSD_PROT_RST = 8'h00;
  localparam logic [7:0] HSD_UNLOCK_KEY = 8'h96;
  // divider: largest ratio is 1/32, so a new ratio is taken at the wrap of a 5-bit count
  localparam int unsigned HSD_SWITCH_MAX_CYC = 32;
  localparam int unsigned HSD_CNT_W = $clog2(HSD_SWITCH_MAX_CYC);
  localparam logic [2:0] HSD_DIV_MAX_CODE = 3'h5;
  // external bus clock source codes
  localparam logic [3:0] HSD_BUS_HS = 4'h0;
  localparam logic [3:0] HSD_BUS_LS = 4'h1;
  localparam logic [3:0] HSD_BUS_BCLK = 4'h2;
  localparam logic [3:0] HSD_BUS_DIV_FIRST = 4'h4;
  localparam logic [3:0] HSD_BUS_DIV_LAST = 4'h9;
endpackage

/* hsd_top.sv */
// hsd_top: oscillator filter, divider, bus clock select, clock gates and register slave
//
// Chosen here: the Avalon-MM slave port.
`timescale 1ns/10ps
`default_nettype none
// Function
// - filter bit 0 filters input, 1 bypasses
// - divider codes 0-5 ratios, 6-7 undivided
// - divided clock drives system only from high-speed
// - new ratio applied within 32 oscillator cycles
// - bus select code picks one of nine
// - bus source switches at once, not glitch-free
// - pin shows bus clock only when port assigned
// - bus select resets to high-speed oscillator
// - rom controller halt clock gate, default on
// - core peripheral clock gate, default on
// - writes need unlock key 0x96 in protect
module hsd_top (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [hsd_pkg::HSD_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [hsd_pkg::HSD_DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [hsd_pkg::HSD_DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic high_speed_oscillator,
  input wire logic low_speed_oscillator,
  input wire logic bus_clock,
  input wire logic sysclk_source_is_low_speed,
  input wire logic halt_mode,
  input wire logic clock_output_port_enable,
  output logic system_clock,
  output logic external_bus_clock,
  output logic external_bus_clock_pin,
  output logic rom_controller_clock,
  output logic core_peripheral_clock
);
  import hsd_pkg::*;

  // ratio code to number of halvings; undefined codes give the undivided clock
  function automatic logic [2:0] ratio_log2(input logic [2:0] code);
    ratio_log2 = (code > HSD_DIV_MAX_CODE) ? 3'h0 : code;
  endfunction

  // divided clock taken from the free-running count; zero halvings is the clock itself
  function automatic logic div_tap(input logic [HSD_CNT_W-1:0] cnt, input logic hs,
                                   input logic [2:0] lg);
    if (lg == 3'h0) begin
      div_tap = hs;
    end else begin
      div_tap = cnt[lg - 3'h1];
    end
  endfunction

  // ---------------- register slave ----------------
  logic wait_q, wait_d;
  logic [HSD_DATA_W-1:0] rdata_q, rdata_d;
  logic nf_bypass_q, nf_bypass_d;
  logic [2:0] hs_divide_ratio_q, hs_divide_ratio_d;
  logic [3:0] bus_clock_source_code_q, bus_clock_source_code_d;
  logic rom_ctrl_halt_clock_gate_q, rom_ctrl_halt_clock_gate_d;
  logic pclk_gate_q, pclk_gate_d;
  logic [7:0] write_unlock_key_q, write_unlock_key_d;
  logic [2:0] applied_ratio_q, applied_ratio_d;

  logic [14:0] idx;
  logic word_ok;
  logic take;
  logic unlocked;
  logic in_prot_range;
  logic wr_low;
  logic [7:0] wbyte;

  assign idx = avs_address[HSD_ADDR_W-1:2];
  assign word_ok = (avs_address[1:0] == 2'h0);
  // the request is taken at the edge where waitrequest is seen low
  assign take = (avs_read | avs_write) & ~wait_q;
  assign unlocked = (write_unlock_key_q == HSD_UNLOCK_KEY);
  assign in_prot_range = (idx >= HSD_IDX_PROT_LO) && (idx <= HSD_IDX_PROT_HI);
  assign wr_low = take & avs_write & avs_byteenable[0] & word_ok;
  assign wbyte = avs_writedata[7:0];

  always_comb begin
    wait_d = 1'b1;
    if ((avs_read | avs_write) && wait_q) begin
      wait_d = 1'b0;
    end
    // read data is prepared one edge early and stands at the taking edge
    rdata_d = rdata_q;
    if (avs_read && wait_q) begin
      rdata_d = '0;
      if (word_ok) begin
        unique case (idx)
          HSD_IDX_NF: rdata_d[HSD_NF_BYPASS_BIT] = nf_bypass_q;
          HSD_IDX_DIV: rdata_d[HSD_DIV_W-1:0] = hs_divide_ratio_q;
          HSD_IDX_BUSSEL: rdata_d[HSD_BUSSEL_W-1:0] = bus_clock_source_code_q;
          HSD_IDX_GATE0: begin
            rdata_d[HSD_GATE_ROM_BIT] = rom_ctrl_halt_clock_gate_q;
            rdata_d[HSD_GATE_PCLK_BIT] = pclk_gate_q;
          end
          HSD_IDX_PROT: rdata_d[7:0] = write_unlock_key_q;
          HSD_IDX_STATUS: begin
            rdata_d[HSD_DIV_W-1:0] = applied_ratio_q;
            rdata_d[HSD_ST_SRC_BIT] = sysclk_source_is_low_speed;
          end
          default: rdata_d = '0;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wait_q <= 1'b1;
      rdata_q <= '0;
    end else begin
      wait_q <= wait_d;
      rdata_q <= rdata_d;
    end
  end

  always_comb begin
    nf_bypass_d = nf_bypass_q;
    hs_divide_ratio_d = hs_divide_ratio_q;
    bus_clock_source_code_d = bus_clock_source_code_q;
    rom_ctrl_halt_clock_gate_d = rom_ctrl_halt_clock_gate_q;
    pclk_gate_d = pclk_gate_q;
    write_unlock_key_d = write_unlock_key_q;
    if (wr_low && idx == HSD_IDX_PROT) begin
      write_unlock_key_d = wbyte;
    end
    if (wr_low && in_prot_range && unlocked) begin
      unique case (idx)
        HSD_IDX_NF: nf_bypass_d = wbyte[HSD_NF_BYPASS_BIT];
        HSD_IDX_DIV: hs_divide_ratio_d = wbyte[HSD_DIV_W-1:0];
        // reserved codes are stored as written; keeping them out is software's job
        HSD_IDX_BUSSEL: bus_clock_source_code_d = wbyte[HSD_BUSSEL_W-1:0];
        HSD_IDX_GATE0: begin
          rom_ctrl_halt_clock_gate_d = wbyte[HSD_GATE_ROM_BIT];
          pclk_gate_d = wbyte[HSD_GATE_PCLK_BIT];
        end
        default: nf_bypass_d = nf_bypass_q;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      nf_bypass_q <= HSD_NF_BYPASS_RST;
      hs_divide_ratio_q <= HSD_DIV_RST;
      bus_clock_source_code_q <= HSD_BUSSEL_RST;
      rom_ctrl_halt_clock_gate_q <= HSD_GATE_ROM_RST;
      pclk_gate_q <= HSD_GATE_PCLK_RST;
      write_unlock_key_q <= HSD_PROT_RST;
    end else begin
      nf_bypass_q <= nf_bypass_d;
      hs_divide_ratio_q <= hs_divide_ratio_d;
      bus_clock_source_code_q <= bus_clock_source_code_d;
      rom_ctrl_halt_clock_gate_q <= rom_ctrl_halt_clock_gate_d;
      pclk_gate_q <= pclk_gate_d;
      write_unlock_key_q <= write_unlock_key_d;
    end
  end

  // ---------------- oscillator input filter ----------------
  // three agreeing samples are needed to move; shorter spikes are dropped
  logic [2:0] hs_hist_q, hs_hist_d;
  logic hs_filt_q, hs_filt_d;
  logic hs_clean;
  logic hs_prev_q, hs_prev_d;
  logic hs_rise;

  always_comb begin
    hs_hist_d = {hs_hist_q[1:0], high_speed_oscillator};
    hs_filt_d = hs_filt_q;
    if (hs_hist_q == 3'h7) begin
      hs_filt_d = 1'b1;
    end else if (hs_hist_q == 3'h0) begin
      hs_filt_d = 1'b0;
    end
    hs_clean = nf_bypass_q ? hs_hist_q[0] : hs_filt_q;
    hs_prev_d = hs_clean;
  end

  assign hs_rise = hs_clean & ~hs_prev_q;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      hs_hist_q <= 3'h0;
      hs_filt_q <= 1'b0;
      hs_prev_q <= 1'b0;
    end else begin
      hs_hist_q <= hs_hist_d;
      hs_filt_q <= hs_filt_d;
      hs_prev_q <= hs_prev_d;
    end
  end

  // ---------------- divider ----------------
  logic [HSD_CNT_W-1:0] hs_cnt_q, hs_cnt_d;
  logic sys_clk_q, sys_clk_d;
  logic hs_divided_clock;
  logic ext_q, ext_d;
  logic ext_pin_q, ext_pin_d;

  always_comb begin
    hs_cnt_d = hs_cnt_q;
    applied_ratio_d = applied_ratio_q;
    if (hs_rise) begin
      hs_cnt_d = hs_cnt_q + 1'b1;
      // ratio changes only at the count wrap: a clean edge, at most 32 cycles late
      if (&hs_cnt_q) begin
        applied_ratio_d = ratio_log2(hs_divide_ratio_q);
      end
    end
  end

  assign hs_divided_clock = div_tap(hs_cnt_q, hs_clean, applied_ratio_q);

  always_comb begin
    sys_clk_d = sysclk_source_is_low_speed ? low_speed_oscillator : hs_divided_clock;
    // switched with no hand-over, so a change may leave a short pulse
    unique case (bus_clock_source_code_q)
      HSD_BUS_HS: ext_d = hs_clean;
      HSD_BUS_LS: ext_d = low_speed_oscillator;
      HSD_BUS_BCLK: ext_d = bus_clock;
      default: begin
        if (bus_clock_source_code_q >= HSD_BUS_DIV_FIRST &&
            bus_clock_source_code_q <= HSD_BUS_DIV_LAST) begin
          ext_d = div_tap(hs_cnt_q, hs_clean, 3'(bus_clock_source_code_q - HSD_BUS_DIV_FIRST));
        end else begin
          ext_d = 1'b0;
        end
      end
    endcase
    ext_pin_d = ext_d & clock_output_port_enable;
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      hs_cnt_q <= '0;
      applied_ratio_q <= HSD_DIV_RST;
      sys_clk_q <= 1'b0;
      ext_q <= 1'b0;
      ext_pin_q <= 1'b0;
    end else begin
      hs_cnt_q <= hs_cnt_d;
      applied_ratio_q <= applied_ratio_d;
      sys_clk_q <= sys_clk_d;
      ext_q <= ext_d;
      ext_pin_q <= ext_pin_d;
    end
  end

  // ---------------- clock gates ----------------
  hsd_clk_gate u_rom_gate (
    .clk(ref_clk),
    .rst(sys_rst),
    .clk_src(sys_clk_q),
    .enable(rom_ctrl_halt_clock_gate_q | ~halt_mode),
    .gated_q(rom_controller_clock)
  );

  hsd_clk_gate u_pclk_gate (
    .clk(ref_clk),
    .rst(sys_rst),
    .clk_src(sys_clk_q),
    .enable(pclk_gate_q),
    .gated_q(core_peripheral_clock)
  );

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  assign system_clock = sys_clk_q;
  assign external_bus_clock = ext_q;
  assign external_bus_clock_pin = ext_pin_q;
endmodule // hsd_top
`default_nettype wire

/* tb_top.sv */
// tb_top: register and clock period tests for hsd_top
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin error_cnt++; \
  $display("mismatch t=%0t got %0h exp %0h", $time, a, e); end end
module tb_top;
  import hsd_pkg::*;
  logic ref_clk = 0, sys_rst = 1, rd_q = 0, wr_q = 0, hs = 0, ls = 0, bc = 0;
  logic ls_src = 0, halt = 0, pen = 0;
  logic [16:0] adr = '0;
  logic [31:0] wd = '0, rd;
  wire logic wait_q, sysc, busc, pin, rom_controller, pclk;
  wire logic [31:0] rdata;
  wire logic [4:0] obs = {pclk, rom_controller, pin, busc, sysc};
  int error_cnt = 0, n_tests = 0, p;
  int bus_per [9] = '{4, 16, 6, 4, 8, 16, 32, 64, 128};
  // reserved bus select codes are never written by the bench
  logic [3:0] bus_code [9] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9};
  logic [14:0] ri [5] = '{HSD_IDX_NF, HSD_IDX_DIV, HSD_IDX_BUSSEL, HSD_IDX_GATE0, HSD_IDX_PROT};
  logic [7:0] rv [5] = '{8'h01, 8'h00, 8'h00, 8'h81, 8'h00};
  hsd_top dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .avs_address(adr), .avs_read(rd_q),
    .avs_write(wr_q), .avs_writedata(wd), .avs_byteenable(4'hF), .avs_readdata(rdata),
    .avs_waitrequest(wait_q), .high_speed_oscillator(hs), .low_speed_oscillator(ls),
    .bus_clock(bc), .sysclk_source_is_low_speed(ls_src), .halt_mode(halt),
    .clock_output_port_enable(pen), .system_clock(sysc), .external_bus_clock(busc),
    .external_bus_clock_pin(pin), .rom_controller_clock(rom_controller), .core_peripheral_clock(pclk));
  initial forever #4 ref_clk = ~ref_clk;
  // oscillators as sampled levels: periods 4, 16 and 6 cycles
  initial forever begin repeat (2) @(posedge ref_clk); hs <= ~hs; end
  initial forever begin repeat (8) @(posedge ref_clk); ls <= ~ls; end
  initial forever begin repeat (3) @(posedge ref_clk); bc <= ~bc; end
  task automatic tally_and_finish;
    $display("errors %0d comparisons %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // byte address is four times the register index
  task automatic xfer(input logic we, input logic [14:0] idx, input logic [7:0] d);
    int n;
    adr <= {idx, 2'b00};
    wd <= {24'h0, d};
    if (we) wr_q <= 1'b1;
    else rd_q <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge ref_clk);
      if (wait_q === 1'b0) break;
    end
    rd = rdata;
    if (n == 20) begin error_cnt++; tally_and_finish(); end
    wr_q <= 1'b0;
    rd_q <= 1'b0;
    @(posedge ref_clk);
  endtask
  // cycles between the second and third rise of one observed clock, 0 if it stands still
  task automatic per(input int i);
    int n, r;
    logic pv;
    p = 0;
    r = 0;
    pv = obs[i];
    for (n = 0; n < 600 && r < 3; n++) begin
      @(posedge ref_clk);
      if (r == 2) p++;
      if (obs[i] && !pv) r++;
      pv = obs[i];
    end
    if (r < 3) p = 0;
  endtask
  initial begin
    int c, n, lg;
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    for (c = 0; c < 5; c++) begin xfer(0, ri[c], 8'h0); `CHK(rd, {24'h0, rv[c]}) end
    xfer(1, HSD_IDX_DIV, 8'h03);
    xfer(0, HSD_IDX_DIV, 8'h0);
    `CHK(rd[7:0], 8'h00)
    xfer(1, HSD_IDX_PROT, HSD_UNLOCK_KEY);
    for (c = 0; c < 8; c++) begin
      lg = (c < 6) ? c : 0;
      xfer(1, HSD_IDX_DIV, 8'(c));
      xfer(0, HSD_IDX_DIV, 8'h0);
      `CHK(rd[7:0], 8'(c))
      // a poll costs three cycles and one oscillator period is four, so this bounds the switch
      for (n = 0; n < HSD_SWITCH_MAX_CYC * 4 / 3 + 2; n++) begin
        xfer(0, HSD_IDX_STATUS, 8'h0);
        if (rd[2:0] === 3'(lg)) break;
      end
      `CHK(rd[2:0], 3'(lg))
      per(0);
      `CHK(p, 4 << lg)
    end
    ls_src <= 1'b1;
    per(0);
    `CHK(p, 16)
    xfer(0, HSD_IDX_STATUS, 8'h0);
    `CHK(rd[HSD_ST_SRC_BIT], 1'b1)
    ls_src <= 1'b0;
    // two-sample hs pulses never pass a three-sample filter
    xfer(1, HSD_IDX_NF, 8'h00);
    per(0);
    `CHK(p, 0)
    xfer(1, HSD_IDX_NF, 8'h01);
    per(0);
    `CHK(p, 4)
    for (c = 0; c < 9; c++) begin
      xfer(1, HSD_IDX_BUSSEL, {4'h0, bus_code[c]});
      per(1);
      `CHK(p, bus_per[c])
    end
    per(2);
    `CHK(p, 0)
    xfer(1, HSD_IDX_BUSSEL, 8'h00);
    pen <= 1'b1;
    per(2);
    `CHK(p, 4)
    halt <= 1'b1;
    per(3);
    `CHK(p, 4)
    xfer(1, HSD_IDX_GATE0, 8'h01);
    per(3);
    `CHK(p, 0)
    halt <= 1'b0;
    per(3);
    `CHK(p, 4)
    xfer(1, HSD_IDX_GATE0, 8'h00);
    per(4);
    `CHK(p, 0)
    xfer(1, HSD_IDX_GATE0, 8'h81);
    per(4);
    `CHK(p, 4)
    xfer(1, HSD_IDX_PROT, 8'h00);
    xfer(1, HSD_IDX_GATE0, 8'h00);
    xfer(0, HSD_IDX_GATE0, 8'h0);
    `CHK(rd[7:0], 8'h81)
    tally_and_finish();
  end
endmodule // tb_top
`default_nettype wire
